// ===== design/clk_ctrl_pkg.sv
// Purpose: shared constants and types of the system clock source and prescaler
// Assumes: 32-bit apb data, word aligned registers
// Notes:   byte offsets of the register map live here
package clk_ctrl_pkg;
    // register map, byte offsets
    localparam logic [7:0] OFS_SYS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_LOOP_CTRL = 8'h04;
    localparam logic [7:0] OFS_DIVIDER   = 8'h08;
    localparam logic [7:0] OFS_MEM_BUS   = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;

    // field widths and positions
    localparam int SEL_W      = 2;
    localparam int DIV_W      = 10;
    localparam int WAIT_W     = 3;
    localparam int BYPASS_BIT = 0;
    localparam int OSCINT_BIT = 1;
    localparam int ST_SEL_LSB = 0;
    localparam int ST_CLK_BIT = 2;
    localparam int ST_DIV_LSB = 4;
    localparam int ST_WS_LSB  = 16;

    // clock source select codes
    localparam logic [1:0] SEL_WAKEUP = 2'h0;
    localparam logic [1:0] SEL_RSVD   = 2'h1;
    localparam logic [1:0] SEL_PLL    = 2'h2;
    localparam logic [1:0] SEL_DIRECT = 2'h3;

    // reset values
    localparam logic [1:0]  RST_SEL    = SEL_WAKEUP;
    localparam logic        RST_BYPASS = 1'h0;
    localparam logic        RST_OSCINT = 1'h1;
    localparam logic [9:0]  RST_DIV    = 10'h000;
    localparam logic [2:0]  RST_WAIT   = 3'h4;

    // flash access sequencer
    typedef enum logic [2:0] {
        FL_IDLE  = 3'h1,
        FL_WAIT  = 3'h2,
        FL_READY = 3'h4
    } flash_state_t;
endpackage

// ===== design/clk_cfg_if.sv
// Purpose: carries clock configuration to the generator and its state back
// Assumes: single clock pclk
// Notes:   none
`timescale 1ns/1ps
interface clk_cfg_if;
    logic [1:0] clock_source_select;
    logic       oscillator_bypass_select;
    logic       osc_internal_select;
    logic [9:0] output_divider_value;
    logic [1:0] active_select;
    logic [9:0] active_divider;
    logic       sys_clk;

    modport gen (
        input  clock_source_select, oscillator_bypass_select, osc_internal_select, output_divider_value,
        output active_select, active_divider, sys_clk
    );
    modport ctl (
        output clock_source_select, oscillator_bypass_select, osc_internal_select, output_divider_value,
        input  active_select, active_divider, sys_clk
    );
endinterface

// ===== design/sys_clk_gen.sv
// Purpose: selects and divides the system clock source
// Assumes: clock sources are levels sampled on pclk
// Notes:   config switches only while the output and the new source are low
`timescale 1ns/1ps
module sys_clk_gen
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // clock sources
    input  wire logic direct_clock_input_pin,
    input  wire logic crystal_input_pin,
    input  wire logic internal_clk_in,
    input  wire logic wakeup_clk_in,
    input  wire logic pll_clk_in,
    // configuration
    clk_cfg_if.gen    cfg
);
    logic [1:0]       sel_reg,    sel_next;
    logic             byp_reg,    byp_next;
    logic             oint_reg,   oint_next;
    logic [DIV_W-1:0] div_reg,    div_next;
    logic [DIV_W-1:0] cnt_reg,    cnt_next;
    logic             osc_prev_reg, osc_prev_next;
    logic             clk_reg,    clk_next;

    // raw level of a source under a given configuration
    function automatic logic raw_level(input logic [1:0] sel, input logic byp, input logic oint);
        logic osc;
        osc = oint ? internal_clk_in : crystal_input_pin;
        unique case (sel)
            SEL_DIRECT: raw_level = direct_clock_input_pin;
            SEL_PLL:    raw_level = byp ? osc : pll_clk_in;
            default:    raw_level = wakeup_clk_in;
        endcase
    endfunction

    logic osc_lvl;
    logic osc_rise;
    logic cfg_change;
    logic [DIV_W-1:0] half;

    always_comb begin
        osc_lvl       = oint_reg ? internal_clk_in : crystal_input_pin;
        osc_rise      = osc_lvl & ~osc_prev_reg;
        half          = DIV_W'((11'(div_reg) + 11'h001) >> 1);
        sel_next      = sel_reg;
        byp_next      = byp_reg;
        oint_next     = oint_reg;
        div_next      = div_reg;
        cnt_next      = cnt_reg;
        osc_prev_next = osc_lvl;
        clk_next      = clk_reg;
        cfg_change    = (cfg.clock_source_select != sel_reg) || (cfg.oscillator_bypass_select != byp_reg)
                     || (cfg.osc_internal_select != oint_reg) || (cfg.output_divider_value != div_reg);
        if (cfg_change && !clk_reg && !raw_level(cfg.clock_source_select, cfg.oscillator_bypass_select,
                                                 cfg.osc_internal_select)) begin
            sel_next  = cfg.clock_source_select; // [R10]
            byp_next  = cfg.oscillator_bypass_select;
            oint_next = cfg.osc_internal_select;
            div_next  = cfg.output_divider_value;
            cnt_next  = '0;
            clk_next  = 1'b0;
        end else if (sel_reg == SEL_PLL && byp_reg) begin
            if (div_reg == '0) begin
                clk_next = osc_lvl; // [R4]
            end else if (osc_rise) begin
                // factor is divider value plus one, up to 1024
                cnt_next = (cnt_reg == div_reg) ? '0 : cnt_reg + 1'b1; // [R3] [R5]
                if (cnt_reg == '0) begin
                    clk_next = 1'b1; // [R2]
                end else if (cnt_reg == half) begin
                    clk_next = 1'b0;
                end
            end
        end else if (sel_reg == SEL_DIRECT) begin
            clk_next = direct_clock_input_pin; // [R1]
        end else if (sel_reg == SEL_PLL) begin
            clk_next = pll_clk_in; // [R8]
        end else begin
            clk_next = wakeup_clk_in; // [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg      <= RST_SEL;
            byp_reg      <= RST_BYPASS;
            oint_reg     <= RST_OSCINT;
            div_reg      <= RST_DIV;
            cnt_reg      <= '0;
            osc_prev_reg <= 1'b0;
            clk_reg      <= 1'b0;
        end else begin
            sel_reg      <= sel_next;
            byp_reg      <= byp_next;
            oint_reg     <= oint_next;
            div_reg      <= div_next;
            cnt_reg      <= cnt_next;
            osc_prev_reg <= osc_prev_next;
            clk_reg      <= clk_next;
        end
    end

    assign cfg.active_select  = sel_reg;
    assign cfg.active_divider = div_reg;
    assign cfg.sys_clk        = clk_reg;
endmodule

// ===== design/clk_ctrl_top.sv
// Purpose: apb register file, clock source control and flash wait-state insertion
// Assumes: all inputs synchronous to pclk
// Notes:   one cycle access phase on apb
// Functional notes
// [R1] select 11 passes the direct clock input undivided, duty cycle kept.
// [R2] select 10 with bypass 1 takes the oscillator through the prescaler.
// [R3] prescaler divides by divider value plus one.
// [R4] factor one passes the oscillator clock with its own duty cycle.
// [R5] largest division factor is 1024.
// [R6] software programs at least 1/2/3/4 wait states for 8/13/17/>17 MHz.
// [R7] wait states apply to non-sequential flash accesses only.
// [R8] select 10 with bypass 0 uses the loop clock.
// [R9] select 00 uses the wakeup clock directly.
// [R10] source and divider changes never cut or glitch clock pulses.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module clk_ctrl_top
    import clk_ctrl_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock sources
    input  wire logic        direct_clock_input_pin,
    input  wire logic        crystal_input_pin,
    input  wire logic        internal_clk_in,
    input  wire logic        wakeup_clk_in,
    input  wire logic        pll_clk_in,
    // system clock
    output logic             sys_clk,
    // flash access
    input  wire logic        flash_req,
    input  wire logic        flash_seq,
    output logic             flash_ready
);
    clk_cfg_if cfg_bus ();

    // register state
    logic [SEL_W-1:0]  system_control_reg,     system_control_next;
    logic              bypass_reg,             bypass_next;
    logic              osc_int_reg,            osc_int_next;
    logic [DIV_W-1:0]  divider_reg,            divider_next;
    logic [WAIT_W-1:0] memory_bus_control_reg, memory_bus_control_next;
    logic [31:0]       prdata_reg,             prdata_next;
    logic              pready_reg,             pready_next;
    logic              pslverr_reg,            pslverr_next;

    // flash sequencer state
    flash_state_t      fl_state_reg,           fl_state_next;
    logic [WAIT_W-1:0] fl_cnt_reg,             fl_cnt_next;
    logic              flash_ready_reg,        flash_ready_next;

    logic              setup;
    logic              wr_take;
    logic              mapped;
    logic [31:0]       rd_val;

    sys_clk_gen u_gen (
        .pclk                   (pclk),
        .presetn                (presetn),
        .direct_clock_input_pin (direct_clock_input_pin),
        .crystal_input_pin      (crystal_input_pin),
        .internal_clk_in        (internal_clk_in),
        .wakeup_clk_in          (wakeup_clk_in),
        .pll_clk_in             (pll_clk_in),
        .cfg                    (cfg_bus)
    );

    assign cfg_bus.clock_source_select      = system_control_reg;
    assign cfg_bus.oscillator_bypass_select = bypass_reg;
    assign cfg_bus.osc_internal_select      = osc_int_reg;
    assign cfg_bus.output_divider_value     = divider_reg;

    // address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        unique case (paddr)
            OFS_SYS_CTRL: begin
                rd_val[SEL_W-1:0] = system_control_reg;
            end
            OFS_LOOP_CTRL: begin
                rd_val[BYPASS_BIT] = bypass_reg;
                rd_val[OSCINT_BIT] = osc_int_reg;
            end
            OFS_DIVIDER: begin
                rd_val[DIV_W-1:0] = divider_reg;
            end
            OFS_MEM_BUS: begin
                rd_val[WAIT_W-1:0] = memory_bus_control_reg;
            end
            OFS_STATUS: begin
                rd_val[ST_SEL_LSB +: SEL_W]  = cfg_bus.active_select;
                rd_val[ST_CLK_BIT]           = cfg_bus.sys_clk;
                rd_val[ST_DIV_LSB +: DIV_W]  = cfg_bus.active_divider;
                rd_val[ST_WS_LSB +: WAIT_W]  = memory_bus_control_reg;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // apb register next state
    always_comb begin
        setup                   = psel && !penable;
        wr_take                 = psel && penable && pready_reg && pwrite && !pslverr_reg;
        system_control_next     = system_control_reg;
        bypass_next             = bypass_reg;
        osc_int_next            = osc_int_reg;
        divider_next            = divider_reg;
        memory_bus_control_next = memory_bus_control_reg;
        prdata_next             = prdata_reg;
        pready_next             = 1'b0;
        pslverr_next            = 1'b0;
        if (setup) begin
            pready_next  = 1'b1;
            pslverr_next = !mapped || (pwrite && paddr == OFS_STATUS);
            prdata_next  = (pwrite || !mapped) ? '0 : rd_val;
        end
        if (wr_take) begin
            unique case (paddr)
                OFS_SYS_CTRL: begin
                    system_control_next = pwdata[SEL_W-1:0];
                end
                OFS_LOOP_CTRL: begin
                    bypass_next  = pwdata[BYPASS_BIT];
                    osc_int_next = pwdata[OSCINT_BIT];
                end
                OFS_DIVIDER: begin
                    divider_next = pwdata[DIV_W-1:0];
                end
                OFS_MEM_BUS: begin
                    memory_bus_control_next = pwdata[WAIT_W-1:0]; // [R6]
                end
                default: begin
                    divider_next = divider_reg;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_control_reg     <= RST_SEL;
            bypass_reg             <= RST_BYPASS;
            osc_int_reg            <= RST_OSCINT;
            divider_reg            <= RST_DIV;
            memory_bus_control_reg <= RST_WAIT;
            prdata_reg             <= '0;
            pready_reg             <= 1'b0;
            pslverr_reg            <= 1'b0;
        end else begin
            system_control_reg     <= system_control_next;
            bypass_reg             <= bypass_next;
            osc_int_reg            <= osc_int_next;
            divider_reg            <= divider_next;
            memory_bus_control_reg <= memory_bus_control_next;
            prdata_reg             <= prdata_next;
            pready_reg             <= pready_next;
            pslverr_reg            <= pslverr_next;
        end
    end

    // flash access sequencer
    always_comb begin
        fl_state_next    = fl_state_reg;
        fl_cnt_next      = fl_cnt_reg;
        flash_ready_next = 1'b0;
        unique case (fl_state_reg)
            FL_IDLE: begin
                if (flash_req) begin
                    if (flash_seq || memory_bus_control_reg == '0) begin
                        fl_state_next    = FL_READY; // [R7]
                        flash_ready_next = 1'b1;
                    end else begin
                        fl_state_next = FL_WAIT; // [R7]
                        fl_cnt_next   = memory_bus_control_reg - 1'b1;
                    end
                end
            end
            FL_WAIT: begin
                if (fl_cnt_reg == '0) begin
                    fl_state_next    = FL_READY;
                    flash_ready_next = 1'b1;
                end else begin
                    fl_cnt_next = fl_cnt_reg - 1'b1;
                end
            end
            FL_READY: begin
                fl_state_next = FL_IDLE;
            end
            default: begin
                fl_state_next = FL_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_state_reg    <= FL_IDLE;
            fl_cnt_reg      <= '0;
            flash_ready_reg <= 1'b0;
        end else begin
            fl_state_reg    <= fl_state_next;
            fl_cnt_reg      <= fl_cnt_next;
            flash_ready_reg <= flash_ready_next;
        end
    end

    // outputs
    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign sys_clk     = cfg_bus.sys_clk;
    assign flash_ready = flash_ready_reg;
endmodule

// ===== tb/clk_ctrl_top_assertions.sv
// Purpose: port checks of clk_ctrl_top
// Assumes: source half periods of two pclk or more
// Notes:   config shadowed from apb writes
`timescale 1ns/1ps
module clk_ctrl_top_assertions
    import clk_ctrl_pkg::*;
(
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // sources
    input wire logic        direct_clock_input_pin,
    input wire logic        crystal_input_pin,
    input wire logic        internal_clk_in,
    input wire logic        wakeup_clk_in,
    input wire logic        pll_clk_in,
    // system clock and flash access
    input wire logic        sys_clk,
    input wire logic        flash_req,
    input wire logic        flash_seq,
    input wire logic        flash_ready
);
    logic [1:0] sel_q;
    logic       byp_q;
    logic       oint_q;
    logic [9:0] div_q;
    logic [2:0] ws_q;
    logic [7:0] age_q;
    wire        wr_hit  = psel & penable & pready & pwrite;
    wire        settled = (age_q > 8'h3C);
    wire        osc     = oint_q ? internal_clk_in : crystal_input_pin;

    // shadow of config, age since last write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q  <= RST_SEL;
            byp_q  <= RST_BYPASS;
            oint_q <= RST_OSCINT;
            div_q  <= RST_DIV;
            ws_q   <= RST_WAIT;
            age_q  <= 8'h00;
        end else if (wr_hit) begin
            age_q <= 8'h00;
            if (paddr == OFS_SYS_CTRL) sel_q <= pwdata[1:0];
            if (paddr == OFS_LOOP_CTRL) byp_q <= pwdata[0];
            if (paddr == OFS_LOOP_CTRL) oint_q <= pwdata[1];
            if (paddr == OFS_DIVIDER) div_q <= pwdata[9:0];
            if (paddr == OFS_MEM_BUS) ws_q <= pwdata[2:0];
        end else if (age_q != 8'hFF) begin
            age_q <= age_q + 8'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_direct_follow: assert property (settled && sel_q == SEL_DIRECT |-> sys_clk == $past(direct_clock_input_pin))
        else $error("sys_clk not following direct input");
    a_presc_undiv: assert property (settled && sel_q == SEL_PLL && byp_q && div_q == 10'h000 |-> sys_clk == $past(osc))
        else $error("sys_clk not following oscillator");
    a_loop_follow: assert property (settled && sel_q == SEL_PLL && !byp_q |-> sys_clk == $past(pll_clk_in))
        else $error("sys_clk not following loop clock");
    a_wakeup_follow: assert property (settled && sel_q[1] == 1'b0 |-> sys_clk == $past(wakeup_clk_in))
        else $error("sys_clk not following wakeup clock");
    a_high_whole: assert property ($rose(sys_clk) |-> sys_clk [*2])
        else $error("short high pulse");
    a_low_whole: assert property ($fell(sys_clk) |-> !sys_clk [*2])
        else $error("short low pulse");
    a_flash_seq: assert property ($rose(flash_req) && flash_seq |=> flash_ready)
        else $error("sequential access delayed");
    a_flash_wait: assert property ($rose(flash_req) && !flash_seq && ws_q != 3'h0 |=> !flash_ready ##[0:7] flash_ready)
        else $error("non-sequential access timing wrong");
    a_apb_answer: assert property (psel && !penable |=> pready && penable)
        else $error("no one-cycle apb answer");
    a_apb_refuse: assert property (pready && paddr > OFS_STATUS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule

bind clk_ctrl_top clk_ctrl_top_assertions i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .direct_clock_input_pin(direct_clock_input_pin), .crystal_input_pin(crystal_input_pin),
    .internal_clk_in(internal_clk_in), .wakeup_clk_in(wakeup_clk_in), .pll_clk_in(pll_clk_in),
    .sys_clk(sys_clk), .flash_req(flash_req), .flash_seq(flash_seq), .flash_ready(flash_ready)
);

// ===== tb/testbench.sv
// Purpose: self-checking bench of clk_ctrl_top
// Assumes: sources are slow square waves on pclk
// Notes:   none
`timescale 1ns/1ps
module testbench
    import clk_ctrl_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, flash_req, flash_seq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, sys_clk, flash_ready;
    logic        s_dir = 1'b0, s_xtal = 1'b0, s_int = 1'b0, s_wu = 1'b0, s_pll = 1'b0;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;

    clk_ctrl_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .direct_clock_input_pin(s_dir), .crystal_input_pin(s_xtal), .internal_clk_in(s_int),
        .wakeup_clk_in(s_wu), .pll_clk_in(s_pll), .sys_clk(sys_clk),
        .flash_req(flash_req), .flash_seq(flash_seq), .flash_ready(flash_ready)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // source waves and timeout
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        s_dir <= ((cyc / 3) % 2) != 0;
        s_xtal <= ((cyc / 4) % 2) != 0;
        s_int <= ((cyc / 5) % 2) != 0;
        s_wu <= ((cyc / 7) % 2) != 0;
        s_pll <= ((cyc / 2) % 2) != 0;
        if (cyc == 50000) begin
            n_mismatch++;
            close_out();
        end
    end

    task close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("write error flag", {31'h0, ee}, {31'h0, e});
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read error flag", {31'h0, ee}, {31'h0, e});
        chk("read data", x, r & m);
    endtask

    function logic src(input logic [1:0] s, input logic [1:0] l);
        case (s)
            SEL_DIRECT: return s_dir;
            SEL_PLL: return l[0] ? (l[1] ? s_int : s_xtal) : s_pll;
            default: return s_wu;
        endcase
    endfunction

    task t_regs();
        rd(OFS_SYS_CTRL, 32'h0, 32'hFFFFFFFF, 1'b0);
        rd(OFS_LOOP_CTRL, 32'h2, 32'hFFFFFFFF, 1'b0);
        rd(OFS_DIVIDER, 32'h0, 32'hFFFFFFFF, 1'b0);
        rd(OFS_MEM_BUS, 32'h4, 32'hFFFFFFFF, 1'b0);
        rd(OFS_STATUS, 32'h00040000, 32'hFFFFFFFB, 1'b0);
        rd(8'h14, 32'h0, 32'hFFFFFFFF, 1'b1);
        wr(OFS_STATUS, 32'h3, 1'b1);
        rd(OFS_STATUS, 32'h00040000, 32'hFFFFFFFB, 1'b0);
        $display("test regs done");
    endtask

    task t_modes();
        logic [1:0] ms [6];
        logic [1:0] ml [6];
        logic       e;
        ms = '{SEL_DIRECT, SEL_WAKEUP, SEL_RSVD, SEL_PLL, SEL_PLL, SEL_PLL};
        ml = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
        for (int i = 0; i < 6; i++) begin
            wr(OFS_LOOP_CTRL, {30'h0, ml[i]}, 1'b0);
            wr(OFS_DIVIDER, 32'h0, 1'b0);
            wr(OFS_SYS_CTRL, {30'h0, ms[i]}, 1'b0);
            repeat (70) @(posedge pclk);
            #1;
            e = src(ms[i], ml[i]);
            repeat (40) begin
                @(posedge pclk);
                #1;
                chk("sys_clk", {31'h0, e}, {31'h0, sys_clk});
                e = src(ms[i], ml[i]);
            end
            rd(OFS_STATUS, {30'h0, ms[i]}, 32'h3, 1'b0);
        end
        $display("test modes done");
    endtask

    task edge_wait(input logic v, inout int n);
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (sys_clk !== v);
    endtask

    task t_divide();
        logic [9:0] dv [3];
        int         n, hi;
        dv = '{10'h001, 10'h002, 10'h3FF};
        wr(OFS_LOOP_CTRL, 32'h1, 1'b0);
        wr(OFS_SYS_CTRL, {30'h0, SEL_PLL}, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_DIVIDER, {22'h0, dv[i]}, 1'b0);
            repeat (2) begin
                n = 0;
                edge_wait(1'b0, n);
                edge_wait(1'b1, n);
                n = 0;
                edge_wait(1'b0, n);
                hi = n;
                edge_wait(1'b1, n);
            end
            chk("high time", (({22'h0, dv[i]} + 32'h1) >> 1) * 32'h8, hi);
            chk("period", ({22'h0, dv[i]} + 32'h1) * 32'h8, n);
            rd(OFS_STATUS, {18'h0, dv[i], 4'h0}, 32'h3FF0, 1'b0);
        end
        $display("test divide done");
    endtask

    task t_flash();
        logic [2:0] ws [3];
        int         n;
        ws = '{3'h1, 3'h2, 3'h7};
        for (int i = 0; i < 3; i++) begin
            wr(OFS_MEM_BUS, {29'h0, ws[i]}, 1'b0);
            for (int s = 0; s < 2; s++) begin
                @(posedge pclk);
                flash_seq <= (s == 1);
                flash_req <= 1'b1;
                n = 0;
                do begin
                    @(posedge pclk);
                    #1;
                    n++;
                end while (flash_ready !== 1'b1);
                @(posedge pclk);
                flash_req <= 1'b0;
                chk("flash latency", (s == 1) ? 32'h1 : {29'h0, ws[i]} + 32'h1, n);
                repeat (2) @(posedge pclk);
            end
        end
        $display("test flash done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        flash_req = 1'b0;
        flash_seq = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_divide();
        t_flash();
        close_out();
    end
endmodule
